// ===== pca_defines.vh
// constants for the configuration prom address control block
// assumes a 125 MHz system clock; included by pca_top.v and pca_fifo.v
`ifndef PCA_DEFINES_VH
`define PCA_DEFINES_VH

`define PCA_AW        16
`define PCA_DW        8
`define PCA_CLK_NS    8
`define PCA_POR_NS    2000
`define PCA_POR_CYC   ((`PCA_POR_NS + `PCA_CLK_NS - 1) / `PCA_CLK_NS)
`define PCA_CFP_NS    400
`define PCA_CFP_CYC   (`PCA_CFP_NS / `PCA_CLK_NS)
`define PCA_OSC_HALF  4'h4
`define PCA_FIFO_D    16
`define PCA_FIFO_AW   4
`define PCA_REV0_BASE 16'h0000
`define PCA_REV1_BASE 16'h4000
`define PCA_REV2_BASE 16'h8000
`define PCA_REV3_BASE 16'hc000
`define PCA_REV_SPAN  16'h3fff
`define PCA_BIT_LAST  3'h7

`endif

// ===== pca_fifo.v
// word fifo between stored-data prefetch and the output pins
// assumes one clock, synchronous active-high reset and flush
`timescale 1ns/1ns
`include "pca_defines.vh"

module pca_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          clk,
  input  wire          sys_rst,
  input  wire          flush,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output wire          in_ready,
  output wire [W-1:0]  out_data,
  output wire          out_valid,
  input  wire          out_ready
);
  reg [W-1:0]  mem_r [0:D-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0]   cnt_r;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_r != D);
  assign out_valid = (cnt_r != 0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (sys_rst | flush) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ===== pca_top.v
// address control of a configuration prom streaming a stored bitstream
// assumes pins sampled synchronously to clk; storage read with one-cycle latency
// How it works
// - a selected external clock rising edge advances the counter only with chip select low, gate high, pulse pin high and, in parallel mode, busy low.
// - a control input chooses the internal oscillator or the external clock pin as the sequence clock.
// - while the gate/reset pin is low the counter stays reset and data and clock outputs float.
// - the gate/reset pin is open drain and the device pulls it low until its power-on hold ends.
// - the gate/reset pin is always active low with no polarity option.
// - chip select high means standby, counter reset and floating data and clock outputs.
// - a reconfigure command pulses the open-drain configuration pulse pin low.
// - a rising edge on the pulse pin samples the revision and loads that revision's start address.
// - in parallel mode busy high freezes the word on the pins; the first clock edge after it falls shows the next word.
// - chain select out goes low only with chip select low, gate high and counter past terminal count or revision absent.
`timescale 1ns/1ns
`include "pca_defines.vh"

module pca_top (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire                ext_clk_in,
  input  wire                chip_sel_n,
  input  wire                oe_rst_n_in,
  output reg                 oe_rst_n_out,
  output reg                 oe_rst_n_oe,
  input  wire                config_pulse_n_in,
  output reg                 config_pulse_n_out,
  output reg                 config_pulse_n_oe,
  input  wire                reconfig_cmd,
  input  wire                busy,
  input  wire                par_mode,
  input  wire                use_int_osc,
  input  wire                clock_output_pin_enable,
  input  wire [1:0]          rev_select,
  input  wire [3:0]          rev_present,
  output reg  [`PCA_AW-1:0]  mem_addr,
  output reg                 mem_rd,
  input  wire [`PCA_DW-1:0]  mem_data,
  output reg  [`PCA_DW-1:0]  data_out_bus,
  output reg  [`PCA_DW-1:0]  data_out_oe,
  output reg                 clock_output_pin,
  output reg                 clock_output_oe,
  output reg                 chain_select_out_n,
  output reg  [`PCA_AW-1:0]  addr_count,
  output reg                 por_done
);
  localparam integer POR_CYC_I = `PCA_POR_CYC;
  localparam integer CFP_CYC_I = `PCA_CFP_CYC;
  localparam [11:0]  POR_CYC   = POR_CYC_I[11:0];
  localparam [11:0]  CFP_CYC   = CFP_CYC_I[11:0];
  localparam [2:0]  ST_POR  = 3'b001;
  localparam [2:0]  ST_IDLE = 3'b010;
  localparam [2:0]  ST_RUN  = 3'b100;

  reg  [2:0]          state_r;
  reg  [11:0]         por_cnt_r;
  reg  [11:0]         cfp_cnt_r;
  reg                 ext_prev_r;
  reg                 cf_prev_r;
  reg  [3:0]          osc_cnt_r;
  reg                 osc_r;
  reg  [1:0]          rev_r;
  reg  [`PCA_AW-1:0]  fetch_r;
  reg                 inflight_r;
  reg                 past_tc_r;
  reg  [2:0]          bit_r;
  reg  [`PCA_DW-1:0]  shift_r;
  reg  [`PCA_AW-1:0]  base_nxt;
  wire [`PCA_AW-1:0]  rev_end;
  wire                ext_rise;
  wire                osc_rise;
  wire                cf_rise;
  wire                held_rst;
  wire                src_edge;
  wire                adv_ok;
  wire                advance;
  wire                need_byte;
  wire                flush;
  wire                fifo_in_ready;
  wire                fifo_out_valid;
  wire [`PCA_DW-1:0]  fifo_out_data;
  wire                fifo_pop;
  wire                terminal_count;

  // start address of the revision in effect
  always @* begin
    case (cf_rise ? rev_select : rev_r)
      2'h0:    base_nxt = `PCA_REV0_BASE;
      2'h1:    base_nxt = `PCA_REV1_BASE;
      2'h2:    base_nxt = `PCA_REV2_BASE;
      default: base_nxt = `PCA_REV3_BASE;
    endcase
  end

  assign rev_end  = base_nxt + `PCA_REV_SPAN;
  assign ext_rise = ext_clk_in & ~ext_prev_r;
  assign osc_rise = (osc_cnt_r == `PCA_OSC_HALF - 4'h1) & ~osc_r;
  assign cf_rise  = config_pulse_n_in & ~cf_prev_r;
  // fixed active-low sense on the gate/reset pin
  assign held_rst = ~oe_rst_n_in | chip_sel_n | (state_r != ST_RUN);
  assign src_edge = use_int_osc ? osc_rise : ext_rise;
  assign adv_ok   = ~held_rst & config_pulse_n_in & ~(par_mode & busy);
  assign need_byte = par_mode | (bit_r == `PCA_BIT_LAST);
  assign advance  = src_edge & adv_ok & ~past_tc_r & (~need_byte | fifo_out_valid);
  assign fifo_pop = advance & need_byte;
  assign flush    = held_rst | cf_rise;
  assign terminal_count = (addr_count == rev_end);

  pca_fifo #(
    .W  (`PCA_DW),
    .D  (`PCA_FIFO_D),
    .AW (`PCA_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (flush),
    .in_data   (mem_data),
    .in_valid  (inflight_r & ~flush),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  // power-on hold, then operation
  always @(posedge clk) begin
    if (sys_rst) begin
      state_r      <= ST_POR;
      por_cnt_r    <= 12'h000;
      por_done     <= 1'b0;
      oe_rst_n_out <= 1'b0;
      oe_rst_n_oe  <= 1'b1;
    end else begin
      oe_rst_n_out <= 1'b0;
      case (state_r)
        ST_POR: begin
          oe_rst_n_oe <= 1'b1;
          if (por_cnt_r == POR_CYC - 12'h001) begin
            state_r     <= ST_IDLE;
            por_done    <= 1'b1;
            oe_rst_n_oe <= 1'b0;
          end else begin
            por_cnt_r <= por_cnt_r + 12'h001;
          end
        end
        ST_IDLE: begin
          oe_rst_n_oe <= 1'b0;
          state_r     <= ST_RUN;
        end
        ST_RUN: begin
          oe_rst_n_oe <= 1'b0;
        end
        default: begin
          state_r     <= ST_POR;
          oe_rst_n_oe <= 1'b1;
        end
      endcase
    end
  end

  // edge history and internal oscillator
  always @(posedge clk) begin
    if (sys_rst) begin
      ext_prev_r <= 1'b0;
      cf_prev_r  <= 1'b1;
      osc_cnt_r  <= 4'h0;
      osc_r      <= 1'b0;
    end else begin
      ext_prev_r <= ext_clk_in;
      cf_prev_r  <= config_pulse_n_in;
      if (osc_cnt_r == `PCA_OSC_HALF - 4'h1) begin
        osc_cnt_r <= 4'h0;
        osc_r     <= ~osc_r;
      end else begin
        osc_cnt_r <= osc_cnt_r + 4'h1;
      end
    end
  end

  // reconfigure command drives the pulse pin low
  always @(posedge clk) begin
    if (sys_rst) begin
      cfp_cnt_r          <= 12'h000;
      config_pulse_n_out <= 1'b0;
      config_pulse_n_oe  <= 1'b0;
    end else begin
      config_pulse_n_out <= 1'b0;
      if (reconfig_cmd) begin
        cfp_cnt_r         <= CFP_CYC;
        config_pulse_n_oe <= 1'b1;
      end else if (cfp_cnt_r != 12'h000) begin
        cfp_cnt_r         <= cfp_cnt_r - 12'h001;
        config_pulse_n_oe <= (cfp_cnt_r != 12'h001);
      end else begin
        config_pulse_n_oe <= 1'b0;
      end
    end
  end

  // revision capture, address counter and prefetch
  always @(posedge clk) begin
    if (sys_rst) begin
      rev_r      <= 2'h0;
      addr_count <= `PCA_REV0_BASE;
      fetch_r    <= `PCA_REV0_BASE;
      mem_addr   <= `PCA_REV0_BASE;
      mem_rd     <= 1'b0;
      inflight_r <= 1'b0;
      past_tc_r  <= 1'b0;
    end else begin
      mem_rd     <= 1'b0;
      // a read cut by a flush must not land after it
      inflight_r <= mem_rd & ~flush;
      if (cf_rise) begin
        rev_r      <= rev_select;
        addr_count <= base_nxt;
        fetch_r    <= base_nxt;
        past_tc_r  <= 1'b0;
      end else if (held_rst) begin
        addr_count <= base_nxt;
        fetch_r    <= base_nxt;
        past_tc_r  <= 1'b0;
      end else begin
        if (advance) begin
          addr_count <= addr_count + 1'b1;
          past_tc_r  <= terminal_count;
        end
        if (~mem_rd & ~inflight_r & fifo_in_ready & (fetch_r <= rev_end)) begin
          mem_addr <= fetch_r;
          mem_rd   <= 1'b1;
          fetch_r  <= fetch_r + 1'b1;
        end
      end
    end
  end

  // data pins, clock output and chain select out
  always @(posedge clk) begin
    if (sys_rst) begin
      bit_r              <= `PCA_BIT_LAST;
      shift_r            <= {`PCA_DW{1'b0}};
      data_out_bus       <= {`PCA_DW{1'b0}};
      data_out_oe        <= {`PCA_DW{1'b0}};
      clock_output_pin   <= 1'b0;
      clock_output_oe    <= 1'b0;
      chain_select_out_n <= 1'b1;
    end else begin
      if (flush) begin
        bit_r <= `PCA_BIT_LAST;
      end else if (advance & par_mode) begin
        data_out_bus <= fifo_out_data;
      end else if (advance) begin
        bit_r <= bit_r + 3'h1;
        if (need_byte) begin
          data_out_bus <= {{(`PCA_DW-1){1'b0}}, fifo_out_data[`PCA_DW-1]};
          shift_r      <= {fifo_out_data[`PCA_DW-2:0], 1'b0};
        end else begin
          data_out_bus <= {{(`PCA_DW-1){1'b0}}, shift_r[`PCA_DW-1]};
          shift_r      <= {shift_r[`PCA_DW-2:0], 1'b0};
        end
      end
      data_out_oe <= held_rst ? {`PCA_DW{1'b0}} :
                     par_mode ? {`PCA_DW{1'b1}} : {{(`PCA_DW-1){1'b0}}, 1'b1};
      clock_output_pin   <= use_int_osc ? osc_r : ext_clk_in;
      clock_output_oe    <= clock_output_pin_enable & ~held_rst;
      chain_select_out_n <= ~(~chip_sel_n & oe_rst_n_in &
                              (past_tc_r | ~rev_present[rev_r]));
    end
  end
endmodule

// ===== pca_fpga.sv
// far-side model: configuring logic clocking the prom, open-drain wires
// assumes pull-ups on both open-drain wires; clock parked low when idle
`timescale 1ns/1ns
module pca_fpga (
  input  wire clk,
  input  wire run,
  input  wire gate_low,
  input  wire pulse_low,
  input  wire dev_gate_oe,
  input  wire dev_pulse_oe,
  output reg  ext_clk,
  output wire gate_n,
  output wire pulse_n
);
  reg [1:0] div_r;
  initial begin
    ext_clk = 1'b0;
    div_r = 2'h0;
  end
  // clock only while enabled, one rise every four cycles
  always @(posedge clk) begin
    div_r <= run ? div_r + 2'h1 : 2'h0;
    ext_clk <= run & div_r[1];
  end
  assign gate_n  = ~(dev_gate_oe | gate_low);
  assign pulse_n = ~(dev_pulse_oe | pulse_low);
endmodule

// ===== pca_chk_chk.sv
// assertions on the pins of the address control block
// assumes bound into pca_top; one clock, synchronous reset
`timescale 1ns/1ns
`include "pca_defines.vh"
module pca_chk (
  input wire               clk,
  input wire               sys_rst,
  input wire               ext_clk_in,
  input wire               chip_sel_n,
  input wire               oe_rst_n_in,
  input wire               oe_rst_n_oe,
  input wire               config_pulse_n_in,
  input wire               config_pulse_n_oe,
  input wire               reconfig_cmd,
  input wire               busy,
  input wire               par_mode,
  input wire               use_int_osc,
  input wire [1:0]         rev_select,
  input wire [`PCA_AW-1:0] addr_count,
  input wire [`PCA_DW-1:0] data_out_bus,
  input wire [`PCA_DW-1:0] data_out_oe,
  input wire               clock_output_oe,
  input wire               clock_output_pin,
  input wire               oe_rst_n_out,
  input wire               config_pulse_n_out,
  input wire               chain_select_out_n,
  input wire               por_done
);
  reg [8:0] por_cnt_r;
  reg [6:0] cf_cnt_r;
  // cycles of power-on hold and of own pulse drive
  always @(posedge clk) begin
    if (sys_rst) begin
      por_cnt_r <= 9'h000;
      cf_cnt_r  <= 7'h00;
    end else begin
      por_cnt_r <= por_done ? por_cnt_r : por_cnt_r + 9'h001;
      cf_cnt_r  <= config_pulse_n_oe ? cf_cnt_r + 7'h01 : 7'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_por_pull; !por_done |-> oe_rst_n_oe; endproperty
  a_por_pull: assert property (p_por_pull) else $error("gate not held");
  property p_por_len; $rose(por_done) |-> por_cnt_r >= 9'd249 && por_cnt_r <= 9'd251; endproperty
  a_por_len: assert property (p_por_len) else $error("hold length");
  property p_gate;
    (!oe_rst_n_in && config_pulse_n_in) [*3] |->
      data_out_oe == 8'h00 && !clock_output_oe && $stable(addr_count);
  endproperty
  a_gate: assert property (p_gate) else $error("gate low ignored");
  property p_cs;
    (chip_sel_n && config_pulse_n_in) [*3] |->
      data_out_oe == 8'h00 && !clock_output_oe && $stable(addr_count);
  endproperty
  a_cs: assert property (p_cs) else $error("standby ignored");
  property p_busy;
    par_mode && busy && oe_rst_n_in && !chip_sel_n && config_pulse_n_in &&
      $past(config_pulse_n_in) |=>
      $stable(data_out_bus) && $stable(addr_count);
  endproperty
  a_busy: assert property (p_busy) else $error("busy ignored");
  property p_idle;
    !use_int_osc && !ext_clk_in && oe_rst_n_in && !chip_sel_n && config_pulse_n_in &&
      $past(config_pulse_n_in) |=>
      $stable(addr_count);
  endproperty
  a_idle: assert property (p_idle) else $error("advance without edge");
  property p_rev; $rose(config_pulse_n_in) |=> addr_count == {$past(rev_select), 14'h0000}; endproperty
  a_rev: assert property (p_rev) else $error("revision base");
  property p_cf_len; $fell(config_pulse_n_oe) |-> cf_cnt_r == 7'd50; endproperty
  a_cf_len: assert property (p_cf_len) else $error("pulse length");
  property p_cf_why; $rose(config_pulse_n_oe) |-> $past(reconfig_cmd); endproperty
  a_cf_why: assert property (p_cf_why) else $error("pulse uncaused");
  property p_chain; !chain_select_out_n |-> !$past(chip_sel_n) && $past(oe_rst_n_in); endproperty
  a_chain: assert property (p_chain) else $error("chain low");
  property p_od; oe_rst_n_out == 1'b0 && config_pulse_n_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("open drain high");
  property p_ckout; !use_int_osc |=> clock_output_pin == $past(ext_clk_in); endproperty
  a_ckout: assert property (p_ckout) else $error("clock out source");
  c_busy: cover property (par_mode && busy && !chip_sel_n);
  c_rev: cover property ($rose(config_pulse_n_in));
  c_chain: cover property ($fell(chain_select_out_n));
endmodule
bind pca_top pca_chk u_pca_chk (.clk(clk), .sys_rst(sys_rst), .ext_clk_in(ext_clk_in),
  .chip_sel_n(chip_sel_n), .oe_rst_n_in(oe_rst_n_in), .oe_rst_n_oe(oe_rst_n_oe),
  .config_pulse_n_in(config_pulse_n_in), .config_pulse_n_oe(config_pulse_n_oe),
  .reconfig_cmd(reconfig_cmd), .busy(busy), .par_mode(par_mode), .use_int_osc(use_int_osc),
  .rev_select(rev_select), .addr_count(addr_count), .data_out_bus(data_out_bus),
  .data_out_oe(data_out_oe), .clock_output_oe(clock_output_oe),
  .clock_output_pin(clock_output_pin), .oe_rst_n_out(oe_rst_n_out),
  .config_pulse_n_out(config_pulse_n_out),
  .chain_select_out_n(chain_select_out_n), .por_done(por_done));

// ===== tb.sv
// bench for the address control block with far-side model and storage
// assumes design, far-side model and checker compiled first
`timescale 1ns/1ns
`include "pca_defines.vh"
module tb;
  reg                clk, sys_rst, run, gate_low, pulse_low, chip_sel_n, reconfig_cmd;
  reg                busy, par_mode, use_int_osc;
  reg  [1:0]         rev_select;
  reg  [3:0]         rev_present;
  reg  [`PCA_DW-1:0] mem_data;
  wire               ext_clk_in, gate_n, pulse_n, gate_oe, pulse_oe, por_done, ceo_n, ck_oe;
  wire               mem_rd;
  wire [`PCA_DW-1:0] dq, dq_oe;
  wire [`PCA_AW-1:0] mem_addr, addr_count;
  integer            errors, checked, i, n;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // storage answers one cycle after the address
  always @(posedge clk) mem_data <= mem_rd ? (mem_addr[7:0] ^ 8'h3c) : 8'hff;
  pca_fpga u_pca_fpga (.clk(clk), .run(run), .gate_low(gate_low), .pulse_low(pulse_low),
    .dev_gate_oe(gate_oe), .dev_pulse_oe(pulse_oe), .ext_clk(ext_clk_in), .gate_n(gate_n),
    .pulse_n(pulse_n));
  pca_top u_pca_top (.clk(clk), .sys_rst(sys_rst), .ext_clk_in(ext_clk_in),
    .chip_sel_n(chip_sel_n), .oe_rst_n_in(gate_n), .oe_rst_n_out(), .oe_rst_n_oe(gate_oe),
    .config_pulse_n_in(pulse_n), .config_pulse_n_out(), .config_pulse_n_oe(pulse_oe),
    .reconfig_cmd(reconfig_cmd), .busy(busy), .par_mode(par_mode),
    .use_int_osc(use_int_osc), .clock_output_pin_enable(1'b1), .rev_select(rev_select),
    .rev_present(rev_present), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_data(mem_data),
    .data_out_bus(dq), .data_out_oe(dq_oe), .clock_output_pin(), .clock_output_oe(ck_oe),
    .chain_select_out_n(ceo_n), .addr_count(addr_count), .por_done(por_done));
  task chk(input [95:0] what, input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  task edges(input integer k);
    begin
      run = 1'b1;
      tick(4 * k);
      run = 1'b0;
      tick(4);
    end
  endtask
  task summarize;
    begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  task t_por;
    begin
      chk("por pull", {15'h0, gate_oe}, 16'h1);
      for (n = 0; por_done !== 1'b1; n = n + 1) begin
        if (n > 400) begin
          errors = errors + 1;
          summarize;
        end
        tick(1);
      end
      chk("por len", {15'h0, n >= 248 && n <= 252}, 16'h1);
      tick(2);
      chk("por free", {15'h0, gate_oe}, 16'h0);
      tick(40);
    end
  endtask
  task t_adv;
    begin
      edges(5);
      chk("adv addr", addr_count, 16'h0005);
      chk("adv data", {dq_oe, dq}, 16'hff38);
      busy = 1'b1;
      edges(3);
      chk("busy", {dq, addr_count[7:0]}, 16'h3805);
      busy = 1'b0;
      edges(1);
      chk("unbusy", {dq, addr_count[7:0]}, 16'h3906);
    end
  endtask
  task t_gate;
    begin
      gate_low = 1'b1;
      edges(2);
      chk("gate", {7'h0, ck_oe, dq_oe}, 16'h0);
      chk("gate addr", addr_count, 16'h0);
      gate_low = 1'b0;
      tick(40);
      edges(3);
      chk("gate high", addr_count, 16'h3);
      chip_sel_n = 1'b1;
      edges(2);
      chk("standby", {7'h0, ck_oe, dq_oe}, 16'h0);
      chk("sb addr", addr_count, 16'h0);
      chip_sel_n = 1'b0;
      tick(40);
    end
  endtask
  task t_pulse;
    for (i = 0; i < 4; i = i + 1) begin
      rev_select = i[1:0];
      pulse_low = 1'b1;
      edges(2);
      pulse_low = 1'b0;
      tick(3);
      chk("rev base", addr_count, {i[1:0], 14'h0});
      tick(40);
      edges(2);
      chk("rev step", {dq, addr_count[7:0]}, 16'h3d02);
    end
  endtask
  task t_recfg;
    begin
      rev_select = 2'h1;
      reconfig_cmd = 1'b1;
      tick(1);
      reconfig_cmd = 1'b0;
      for (n = 0; pulse_oe === 1'b1; n = n + 1) begin
        if (n > 100) begin
          errors = errors + 1;
          summarize;
        end
        tick(1);
      end
      chk("pulse len", n[15:0], 16'd50);
      tick(3);
      chk("pulse reload", addr_count, 16'h4000);
    end
  endtask
  task t_osc;
    begin
      tick(40);
      use_int_osc = 1'b1;
      tick(80);
      chk("osc runs", {15'h0, addr_count > 16'h4008}, 16'h1);
      use_int_osc = 1'b0;
      tick(4);
      n = addr_count;
      tick(20);
      chk("osc off", addr_count, n[15:0]);
      par_mode = 1'b0;
      busy = 1'b1;
      edges(2);
      chk("serial", {dq_oe, 8'h0} | (addr_count - n[15:0]), 16'h0102);
      n = n ^ 32'h3c;
      chk("serial bit", {8'h0, dq}, {15'h0, n[6]});
      busy = 1'b0;
      par_mode = 1'b1;
    end
  endtask
  task t_chain;
    begin
      chk("chain idle", {15'h0, ceo_n}, 16'h1);
      rev_present = 4'he;
      rev_select = 2'h0;
      pulse_low = 1'b1;
      tick(2);
      pulse_low = 1'b0;
      tick(4);
      chk("chain lo", {15'h0, ceo_n}, 16'h0);
      chip_sel_n = 1'b1;
      tick(3);
      chk("chain hi", {15'h0, ceo_n}, 16'h1);
    end
  endtask
  initial begin
    errors = 0;
    checked = 0;
    sys_rst = 1'b1;
    {run, gate_low, pulse_low, chip_sel_n, reconfig_cmd, busy, use_int_osc} = 7'h00;
    par_mode = 1'b1;
    rev_select = 2'h0;
    rev_present = 4'hf;
    tick(16);
    sys_rst = 1'b0;
    t_por;
    t_adv;
    t_gate;
    t_pulse;
    t_recfg;
    t_osc;
    t_chain;
    summarize;
  end
endmodule
